// file: hw/branch_flag_pkg.sv
// shared constants and carrier types of the branch and flag-clear unit
// assumes a single 250 MHz clock domain and an APB master on that clock
package branch_flag_pkg;

    // ------------------------------------------------------------------
    // register map (byte addresses, one aligned 32-bit word each)
    // ------------------------------------------------------------------
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;
    localparam logic [7:0] REG_CMD = 8'h00;
    localparam logic [7:0] REG_STATUS = 8'h04;
    localparam logic [7:0] REG_PC = 8'h08;
    localparam logic [7:0] REG_BANK = 8'h0C;
    localparam logic [7:0] REG_ACC = 8'h10;
    localparam logic [7:0] REG_MEM = 8'h14;
    localparam logic [7:0] REG_OPND = 8'h18;
    localparam logic [7:0] REG_LAST = 8'h1C;

    // ------------------------------------------------------------------
    // processor status bit positions
    // ------------------------------------------------------------------
    localparam int PS_C = 0;
    localparam int PS_Z = 1;
    localparam int PS_I = 2;
    localparam int PS_D = 3;
    localparam int PS_X = 4;
    localparam int PS_M = 5;
    localparam int PS_V = 6;
    localparam int PS_N = 7;
    localparam logic [7:0] PS_RESET = 8'h04;

    // ------------------------------------------------------------------
    // operation codes written into the command register
    // ------------------------------------------------------------------
    localparam int OP_W = 4;
    localparam logic [3:0] OP_NOP = 4'h0;
    localparam logic [3:0] OP_BRANCH_IF_PLUS = 4'h1;
    localparam logic [3:0] OP_BRANCH_ALWAYS = 4'h2;
    localparam logic [3:0] OP_BRANCH_IF_OVERFLOW_CLEAR = 4'h3;
    localparam logic [3:0] OP_BRANCH_IF_OVERFLOW_SET = 4'h4;
    localparam logic [3:0] OP_MEMORY_BIT_CLEAR = 4'h5;
    localparam logic [3:0] OP_CARRY_CLEAR = 4'h6;
    localparam logic [3:0] OP_INTERRUPT_ENABLE = 4'h7;
    localparam logic [3:0] OP_WIDTH_CLEAR = 4'h8;
    localparam logic [3:0] OP_STATUS_BITS_CLEAR = 4'h9;
    localparam logic [3:0] OP_OVERFLOW_CLEAR = 4'hA;
    localparam logic [3:0] OP_COMPARE = 4'hB;

    // ------------------------------------------------------------------
    // field positions of the last-operation register
    // ------------------------------------------------------------------
    localparam int LAST_TAKEN = 0;
    localparam int LAST_ILLEGAL = 1;
    localparam int LAST_OP_LSB = 8;

    // ------------------------------------------------------------------
    // carriers and state
    // ------------------------------------------------------------------
    typedef struct packed {
        logic [7:0] paddr;
        logic psel;
        logic penable;
        logic pwrite;
        logic [31:0] pwdata;
    } apb_req_t;

    typedef struct packed {
        logic [31:0] prdata;
        logic pready;
        logic pslverr;
    } apb_rsp_t;

    typedef struct packed {
        logic [15:0] pc;
        logic [7:0] bank;
        logic [15:0] acc;
        logic [15:0] mem;
        logic [15:0] opnd;
        logic [7:0] ps;
        logic lastTaken;
        logic lastIllegal;
        logic [3:0] lastOp;
        logic [31:0] rdata;
    } core_state_t;

    localparam core_state_t STATE_RESET = '{
        pc: 16'h0000, bank: 8'h00, acc: 16'h0000, mem: 16'h0000,
        opnd: 16'h0000, ps: PS_RESET, lastTaken: 1'b0,
        lastIllegal: 1'b0, lastOp: OP_NOP, rdata: 32'h0000_0000
    };

endpackage

// file: hw/branch_flag_unit.sv
// execution unit for relative branches, flag clears, bit clear and compare
// assumes an APB master on ref_clk; software loads the operands, then
// writes an operation code into the command register to execute it
//
// The APB interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/1ps
`default_nettype none

module branch_flag_unit
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire branch_flag_pkg::apb_req_t apbReq,
    output var branch_flag_pkg::apb_rsp_t apbRsp
);
    import branch_flag_pkg::*;

    // ------------------------------------------------------------------
    // helper functions
    // ------------------------------------------------------------------

    // relative jump: returns {bank change, new pc}; bit 17 = step down,
    // bit 16 = step at all; the offset is a full 16-bit signed value
    function automatic logic [17:0] relJump(input logic [15:0] pc,
                                            input logic [15:0] offset);
        logic [16:0] sum;
        sum = {1'b0, pc} + {offset[15], offset};
        // with the offset sign-extended, bit 16 is set when the true sum
        // leaves 0..FFFF: a carry past FFFF forward or a borrow below
        // zero backward, so it marks a bank step in both directions
        relJump = {offset[15], sum[16], sum[15:0]};
    endfunction

    // compare flags {n, z, c} for accumulator minus memory at given width
    function automatic logic [2:0] cmpFlags(input logic [15:0] a,
                                            input logic [15:0] m,
                                            input logic narrow);
        logic [16:0] diff;
        logic [8:0] diff8;
        logic [2:0] flags;
        diff = {1'b0, a} - {1'b0, m};
        diff8 = {1'b0, a[7:0]} - {1'b0, m[7:0]};
        if (narrow)
        begin
            flags = {diff8[7], diff8[7:0] == 8'h00, ~diff8[8]};
        end
        else
        begin
            flags = {diff[15], diff[15:0] == 16'h0000, ~diff[16]};
        end
        cmpFlags = flags;
    endfunction

    // maps an address to its register, unmapped addresses give 1'b0
    function automatic logic isMapped(input logic [7:0] addr);
        case (addr)
            REG_CMD, REG_STATUS, REG_PC, REG_BANK,
            REG_ACC, REG_MEM, REG_OPND, REG_LAST: isMapped = 1'b1;
            default: isMapped = 1'b0;
        endcase
    endfunction

    // branch condition of an op code; codes that are not branches
    // never jump, so apart from a write to REG_PC the pc only moves through this decode
    function automatic logic branchTaken(input logic [3:0] op,
                                         input logic [7:0] ps);
        logic hit;
        hit = 1'b0;
        case (op)
            OP_BRANCH_IF_PLUS:
            begin
                hit = ~ps[PS_N];
            end
            OP_BRANCH_ALWAYS:
            begin
                hit = 1'b1;
            end
            OP_BRANCH_IF_OVERFLOW_CLEAR:
            begin
                hit = ~ps[PS_V];
            end
            OP_BRANCH_IF_OVERFLOW_SET:
            begin
                hit = ps[PS_V];
            end
            default:
            begin
                hit = 1'b0;
            end
        endcase
        branchTaken = hit;
    endfunction

    // status bits that a clear op zeroes; the execute step applies it
    // as an and-not, so every bit outside the mask keeps its value
    function automatic logic [7:0] clearMask(input logic [3:0] op,
                                             input logic [7:0] pattern);
        logic [7:0] mask;
        mask = 8'h00;
        case (op)
            OP_CARRY_CLEAR:
            begin
                mask[PS_C] = 1'b1;
            end
            OP_INTERRUPT_ENABLE:
            begin
                mask[PS_I] = 1'b1;
            end
            OP_WIDTH_CLEAR:
            begin
                mask[PS_M] = 1'b1;
            end
            OP_STATUS_BITS_CLEAR:
            begin
                mask = pattern;
            end
            OP_OVERFLOW_CLEAR:
            begin
                mask[PS_V] = 1'b1;
            end
            default:
            begin
                mask = 8'h00;
            end
        endcase
        clearMask = mask;
    endfunction

    // register read view; command word and holes read as zero
    function automatic logic [31:0] readWord(input logic [7:0] addr,
                                             input core_state_t s);
        logic [31:0] word;
        word = 32'h0000_0000;
        case (addr)
            REG_STATUS:
            begin
                word[7:0] = s.ps;
            end
            REG_PC:
            begin
                word[15:0] = s.pc;
            end
            REG_BANK:
            begin
                word[7:0] = s.bank;
            end
            REG_ACC:
            begin
                word[15:0] = s.acc;
            end
            REG_MEM:
            begin
                word[15:0] = s.mem;
            end
            REG_OPND:
            begin
                word[15:0] = s.opnd;
            end
            REG_LAST:
            begin
                word[LAST_TAKEN] = s.lastTaken;
                word[LAST_ILLEGAL] = s.lastIllegal;
                word[LAST_OP_LSB +: OP_W] = s.lastOp;
            end
            default:
            begin
                word = 32'h0000_0000;
            end
        endcase
        readWord = word;
    endfunction

    // ------------------------------------------------------------------
    // state
    // ------------------------------------------------------------------
    core_state_t stateQ;
    core_state_t stateD;
    logic setup;
    logic access;
    logic writeHit;
    logic [17:0] jump;
    logic [2:0] nzc;
    logic [3:0] opCode;
    logic branchGo;
    logic [7:0] flagMask;

    // bus phases; the slave never stalls, so access always completes
    assign setup = apbReq.psel & ~apbReq.penable;
    assign access = apbReq.psel & apbReq.penable;
    assign writeHit = access & apbReq.pwrite & isMapped(apbReq.paddr);
    assign opCode = apbReq.pwdata[OP_W - 1:0];
    assign jump = relJump(stateQ.pc, stateQ.opnd);
    assign nzc = cmpFlags(stateQ.acc, stateQ.mem, stateQ.ps[PS_M]);
    assign branchGo = branchTaken(opCode, stateQ.ps);
    assign flagMask = clearMask(opCode, stateQ.opnd[7:0]);

    // handshake is combinational; read data comes from the state flop;
    // one whole-struct assignment keeps a single driver on the port
    assign apbRsp = '{
        prdata: stateQ.rdata,
        pready: 1'b1,
        pslverr: access & ~isMapped(apbReq.paddr)
    };

    // ------------------------------------------------------------------
    // next-state logic: register writes, execution and read capture
    // ------------------------------------------------------------------
    always_comb
    begin
        stateD = stateQ;

        // read data is latched in the setup cycle so it is stable
        // for the whole access phase
        if (setup)
        begin
            stateD.rdata = readWord(apbReq.paddr, stateQ);
        end

        // plain register writes; upper bits of narrow registers drop
        if (writeHit)
        begin
            case (apbReq.paddr)
                REG_STATUS: stateD.ps = apbReq.pwdata[7:0];
                REG_PC: stateD.pc = apbReq.pwdata[15:0];
                REG_BANK: stateD.bank = apbReq.pwdata[7:0];
                REG_ACC: stateD.acc = apbReq.pwdata[15:0];
                REG_MEM: stateD.mem = apbReq.pwdata[15:0];
                REG_OPND: stateD.opnd = apbReq.pwdata[15:0];
                default: stateD.ps = stateQ.ps;
            endcase
        end

        // a command write executes one operation on the held operands
        if (writeHit && apbReq.paddr == REG_CMD)
        begin
            stateD.lastOp = opCode;
            stateD.lastTaken = 1'b0;
            stateD.lastIllegal = 1'b0;
            case (opCode)
                OP_NOP:
                begin
                    stateD.lastTaken = 1'b0;
                end
                OP_BRANCH_IF_PLUS:
                begin
                    stateD.lastTaken = branchGo;
                end
                OP_BRANCH_ALWAYS:
                begin
                    stateD.lastTaken = branchGo;
                end
                OP_BRANCH_IF_OVERFLOW_CLEAR:
                begin
                    stateD.lastTaken = branchGo;
                end
                OP_BRANCH_IF_OVERFLOW_SET:
                begin
                    stateD.lastTaken = branchGo;
                end
                OP_MEMORY_BIT_CLEAR:
                begin
                    // at 8-bit width the upper byte is not part of the
                    // operand and so it is never touched
                    if (stateQ.ps[PS_M])
                    begin
                        stateD.mem[7:0] = stateQ.mem[7:0]
                            & ~stateQ.opnd[7:0];
                    end
                    else
                    begin
                        stateD.mem = stateQ.mem & ~stateQ.opnd;
                    end
                end
                OP_CARRY_CLEAR:
                begin
                    stateD.ps = stateQ.ps & ~flagMask;
                end
                OP_INTERRUPT_ENABLE:
                begin
                    stateD.ps = stateQ.ps & ~flagMask;
                end
                OP_WIDTH_CLEAR:
                begin
                    stateD.ps = stateQ.ps & ~flagMask;
                end
                OP_STATUS_BITS_CLEAR:
                begin
                    // pattern is the second instruction byte, kept in
                    // the low byte of the operand register
                    stateD.ps = stateQ.ps & ~flagMask;
                end
                OP_OVERFLOW_CLEAR:
                begin
                    stateD.ps = stateQ.ps & ~flagMask;
                end
                OP_COMPARE:
                begin
                    // accumulator stays as is; only flags change
                    stateD.ps[PS_N] = nzc[2];
                    stateD.ps[PS_Z] = nzc[1];
                    stateD.ps[PS_C] = nzc[0];
                end
                default:
                begin
                    stateD.lastIllegal = 1'b1;
                end
            endcase

            // a taken branch moves pc; a carry or borrow out of the
            // 16-bit counter steps the program bank register
            if (stateD.lastTaken)
            begin
                stateD.pc = jump[15:0];
                if (jump[16] && !jump[17])
                begin
                    stateD.bank = stateQ.bank + 8'h01;
                end
                else if (jump[16] && jump[17])
                begin
                    stateD.bank = stateQ.bank - 8'h01;
                end
            end
        end
    end

    // ------------------------------------------------------------------
    // state register
    // ------------------------------------------------------------------
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
        begin
            stateQ <= STATE_RESET;
        end
        else
        begin
            stateQ <= stateD;
        end
    end

endmodule

`default_nettype wire

// file: verification/branch_flag_unit_props.sv
// concurrent checks on the APB port of the branch and flag-clear unit
// assumes one clock domain and is attached to the top module by bind
`timescale 1ns/1ps
`default_nettype none

module branch_flag_unit_checker
(
    input wire logic ref_clk,
    input wire logic arst_n,
    input wire branch_flag_pkg::apb_req_t apbReq,
    input wire branch_flag_pkg::apb_rsp_t apbRsp
);
    import branch_flag_pkg::*;

    // ------------------------------------------------------------------
    // helper logic
    // ------------------------------------------------------------------
    logic accessPh;
    logic mapped;
    logic rdStatus;
    logic [3:0] prevOp_q;
    assign accessPh = apbReq.psel && apbReq.penable;
    assign mapped = (apbReq.paddr <= REG_LAST) && (apbReq.paddr[1:0] == 2'h0);
    assign rdStatus = accessPh && !apbReq.pwrite && apbReq.paddr == REG_STATUS;

    // op code of the transfer just finished; reads see its effect next
    always_ff @(posedge ref_clk or negedge arst_n)
    begin
        if (!arst_n)
            prevOp_q <= OP_NOP;
        else if (accessPh && apbRsp.pready)
            prevOp_q <= (apbReq.pwrite && apbReq.paddr == REG_CMD) ?
                apbReq.pwdata[3:0] : OP_NOP;
    end

    default clocking cb @(posedge ref_clk); endclocking
    default disable iff (!arst_n);

    sequence s_access;
        accessPh && apbRsp.pready;
    endsequence
    sequence s_idle;
        !apbReq.psel;
    endsequence
    sequence s_flagRead(logic [3:0] op);
        rdStatus && prevOp_q == op;
    endsequence

    property p_ready;
        apbRsp.pready;
    endproperty
    property p_err;
        accessPh |-> apbRsp.pslverr == !mapped;
    endproperty
    property p_hold;
        s_access ##1 s_idle |-> $stable(apbRsp.prdata);
    endproperty
    property p_cmdZero;
        s_access and (!apbReq.pwrite && apbReq.paddr == REG_CMD)
            |-> apbRsp.prdata == 32'h0;
    endproperty
    property p_unmappedZero;
        accessPh && !apbReq.pwrite && !mapped |-> apbRsp.prdata == 32'h0;
    endproperty
    property p_flagZero(logic [3:0] op, int pos);
        s_flagRead(op) |-> apbRsp.prdata[pos] == 1'b0;
    endproperty

    a_ready: assert property (p_ready) else $error("pready low");
    a_err: assert property (p_err) else $error("pslverr wrong");
    a_hold: assert property (p_hold) else $error("read data moved");
    a_cmdZero: assert property (p_cmdZero) else $error("cmd read not 0");
    a_unmappedZero: assert property (p_unmappedZero) else $error("bad rd");
    a_carry: assert property (p_flagZero(OP_CARRY_CLEAR, PS_C))
        else $error("carry not cleared");
    a_irq: assert property (p_flagZero(OP_INTERRUPT_ENABLE, PS_I))
        else $error("irq disable not cleared");
    a_width: assert property (p_flagZero(OP_WIDTH_CLEAR, PS_M))
        else $error("width flag not cleared");
    a_ovf: assert property (p_flagZero(OP_OVERFLOW_CLEAR, PS_V))
        else $error("overflow not cleared");
endmodule

bind branch_flag_unit branch_flag_unit_checker i_branch_flag_unit_checker (
    .ref_clk(ref_clk), .arst_n(arst_n), .apbReq(apbReq), .apbRsp(apbRsp));

`default_nettype wire

// file: verification/test_branch_flag_unit.sv
// self-checking bench of the branch and flag-clear unit
// drives the APB port directly; no model stands on the far side
`timescale 1ns/1ps
`default_nettype none
`define CHK(nm, ex, got) begin n_checks++; if ((got) !== (ex)) begin \
    errors++; $display("MISMATCH %s exp %0h seen %0h", nm, ex, got); end end

module test_branch_flag_unit;
    import branch_flag_pkg::*;
    logic ref_clk;
    logic arst_n;
    apb_req_t req;
    apb_rsp_t rsp;
    int errors;
    int n_checks;
    logic [31:0] rd;

    branch_flag_unit i_branch_flag_unit(.ref_clk(ref_clk), .arst_n(arst_n),
        .apbReq(req), .apbRsp(rsp));

    initial
    begin
        ref_clk = 1'b0;
        forever #2 ref_clk = ~ref_clk;
    end

    // ------------------------------------------------------------------
    // bus tasks: one idle cycle between transfers avoids double drives
    // ------------------------------------------------------------------
    task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d);
        int k;
        k = 0;
        @(posedge ref_clk);
        req <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge ref_clk);
        req.penable <= 1'b1;
        @(posedge ref_clk);
        while (rsp.pready !== 1'b1 && k < 50)
        begin
            @(posedge ref_clk);
            k++;
        end
        rd = rsp.prdata;
        req.psel <= 1'b0;
        req.penable <= 1'b0;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        apb(1'b1, a, d);
    endtask
    task automatic rdchk(input string nm, input logic [7:0] a, input logic [31:0] e);
        apb(1'b0, a, 32'h0);
        `CHK(nm, e, rd)
    endtask

    // ------------------------------------------------------------------
    // scenarios
    // ------------------------------------------------------------------
    task automatic t_branch;
        logic [3:0] ops [3] = '{OP_BRANCH_IF_PLUS, OP_BRANCH_IF_OVERFLOW_CLEAR,
            OP_BRANCH_IF_OVERFLOW_SET};
        logic [7:0] flg [3] = '{8'h80, 8'h40, 8'h40};
        logic tk;
        rdchk("status", REG_STATUS, 32'h0000_0004);
        for (int i = 0; i < 3; i++)
            for (int s = 0; s < 2; s++)
            begin
                tk = (i == 2) ? s[0] : !s[0];
                wr(REG_STATUS, s[0] ? {24'h0, flg[i]} : 32'h0);
                wr(REG_PC, 32'h0000_1000);
                wr(REG_OPND, 32'h0000_0010);
                wr(REG_CMD, {28'h0, ops[i]});
                rdchk("pc", REG_PC, tk ? 32'h1010 : 32'h1000);
                rdchk("last", REG_LAST, {20'h0, ops[i], 7'h0, tk});
            end
        wr(REG_PC, 32'h0000_FFF0);
        wr(REG_BANK, 32'h0000_0005);
        wr(REG_OPND, 32'h0000_0020);
        wr(REG_CMD, {28'h0, OP_BRANCH_ALWAYS});
        rdchk("pc", REG_PC, 32'h0000_0010);
        rdchk("bank", REG_BANK, 32'h0000_0006);
        wr(REG_OPND, 32'h0000_FFE0);
        wr(REG_CMD, {28'h0, OP_BRANCH_ALWAYS});
        rdchk("pc", REG_PC, 32'h0000_FFF0);
        rdchk("bank", REG_BANK, 32'h0000_0005);
        $display("branch test done");
    endtask

    task automatic t_flags;
        logic [3:0] ops [4] = '{OP_CARRY_CLEAR, OP_INTERRUPT_ENABLE,
            OP_WIDTH_CLEAR, OP_OVERFLOW_CLEAR};
        int pos [4] = '{PS_C, PS_I, PS_M, PS_V};
        for (int i = 0; i < 4; i++)
        begin
            wr(REG_STATUS, 32'h0000_00FF);
            wr(REG_CMD, {28'h0, ops[i]});
            rdchk("status", REG_STATUS, {24'h0, ~(8'h01 << pos[i])});
        end
        wr(REG_STATUS, 32'h0000_00FF);
        wr(REG_OPND, 32'h0000_01A5);
        wr(REG_CMD, {28'h0, OP_STATUS_BITS_CLEAR});
        rdchk("status", REG_STATUS, 32'h0000_005A);
        $display("flag test done");
    endtask

    task automatic t_data;
        wr(REG_STATUS, 32'h0);
        wr(REG_MEM, 32'h0000_FFFF);
        wr(REG_OPND, 32'h0000_0F0F);
        wr(REG_CMD, {28'h0, OP_MEMORY_BIT_CLEAR});
        rdchk("mem", REG_MEM, 32'h0000_F0F0);
        wr(REG_STATUS, 32'h0000_0020);
        wr(REG_MEM, 32'h0000_FFFF);
        wr(REG_OPND, 32'h0000_FFFF);
        wr(REG_CMD, {28'h0, OP_MEMORY_BIT_CLEAR});
        rdchk("mem", REG_MEM, 32'h0000_FF00);
        wr(REG_STATUS, 32'h0);
        wr(REG_ACC, 32'h0000_0005);
        wr(REG_MEM, 32'h0000_0007);
        wr(REG_CMD, {28'h0, OP_COMPARE});
        rdchk("status", REG_STATUS, 32'h0000_0080);
        rdchk("acc", REG_ACC, 32'h0000_0005);
        wr(REG_STATUS, 32'h0000_0020);
        wr(REG_ACC, 32'h0000_0180);
        wr(REG_MEM, 32'h0000_0080);
        wr(REG_CMD, {28'h0, OP_COMPARE});
        rdchk("status", REG_STATUS, 32'h0000_0023);
        rdchk("acc", REG_ACC, 32'h0000_0180);
        rdchk("cmd", REG_CMD, 32'h0);
        rdchk("hole", 8'h20, 32'h0);
        // refused write, no-op and unknown code: only the record moves
        wr(8'h20, 32'h0000_00FF);
        wr(REG_CMD, {28'h0, OP_NOP});
        rdchk("last", REG_LAST, 32'h0000_0000);
        wr(REG_CMD, 32'h0000_000C);
        rdchk("last", REG_LAST, 32'h0000_0C02);
        rdchk("status", REG_STATUS, 32'h0000_0023);
        rdchk("acc", REG_ACC, 32'h0000_0180);
        $display("data test done");
    endtask

    task automatic complete_run;
        $display("checks %0d mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // main sequence after a four-cycle reset
    initial
    begin
        errors = 0;
        n_checks = 0;
        req = '0;
        arst_n = 1'b0;
        repeat (4) @(posedge ref_clk);
        arst_n <= 1'b1;
        t_branch;
        t_flags;
        t_data;
        complete_run;
    end

    // roughly 90 transfers of 3 cycles; some fourteen times that is a hang
    initial
    begin
        repeat (4000) @(posedge ref_clk);
        errors++;
        complete_run;
    end
endmodule

`default_nettype wire
